// ---- pci_master_initiator.sv ----
// PCI initiator: AHB-Lite proxy registers, memory back end and bus sequencer.
`timescale 1ns/1ps
`include "pci_master_initiator_map.svh"
module pci_master_initiator
   import pci_master_pkg::*;
(
   input  wire logic        hclk,                      // System clock, 125 MHz.
   input  wire logic        hresetn,                   // Asynchronous reset, active low.
   input  wire logic        hsel,                      // AHB slave select.
   input  wire logic [31:0] haddr,                     // AHB address.
   input  wire logic [1:0]  htrans,                    // AHB transfer type.
   input  wire logic        hwrite,                    // AHB write strobe.
   input  wire logic [2:0]  hsize,                     // AHB size, word only.
   input  wire logic [31:0] hwdata,                    // AHB write data.
   input  wire logic        hready,                    // AHB bus ready.
   output logic             hreadyout,                 // Slave ready.
   output logic             hresp,                     // Slave response.
   output logic      [31:0] hrdata,                    // Read data.
   input  wire logic        mem_start,                 // Back-end memory request.
   input  wire logic        mem_write,                 // Request is a write.
   input  wire logic [31:0] mem_addr,                  // Byte address of first word.
   input  wire logic [4:0]  mem_count,                 // Words, 1 to 16.
   input  wire logic [3:0]  mem_be,                    // Byte enables, active high.
   input  wire logic [31:0] mem_wdata,                 // Current write word.
   output logic             mem_idle,                  // Request may be taken.
   output logic             mem_ready,                 // One word done.
   output logic      [31:0] mem_rdata,                 // Read word.
   input  wire logic        pci_clk_in,                // PCI clock.
   input  wire logic        bus_grant_in_n,            // Grant.
   input  wire logic        target_ready_in_n,         // Target ready.
   input  wire logic        devsel_in_n,               // Device select.
   input  wire logic        stop_in_n,                 // Target stop.
   input  wire logic        perr_in_n,                 // Parity error.
   input  wire logic        serr_in_n,                 // System error.
   input  wire logic [31:0] ad_in,                     // AD level.
   output logic             bus_request_out_n,         // Request.
   output logic             frame_out_n,               // Frame.
   output logic             frame_oe,                  // Frame enable.
   output logic             initiator_ready_out_n,     // Initiator ready.
   output logic             irdy_oe,                   // Initiator ready enable.
   output logic      [31:0] ad_out,                    // AD drive value.
   output logic             ad_oe,                     // AD enable.
   output logic      [3:0]  command_byte_enable_lines, // Command or enables.
   output logic             cbe_oe                     // Command enable.
);
   logic [38:0] pin_q;
   logic [38:0] pin_rise;

   pin_sync #(.W(39), .INIT(`PIN_INIT)) u_pins (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     ({ad_in, serr_in_n, perr_in_n, stop_in_n, devsel_in_n,
               target_ready_in_n, bus_grant_in_n, pci_clk_in}),
      .q     (pin_q),
      .rise  (pin_rise)
   );

   wire        pci_tick = pin_rise[0];
   wire        gnt_s    = ~pin_q[1];
   wire        trdy_s   = ~pin_q[2];
   wire        devsel_s = ~pin_q[3];
   wire        stop_s   = ~pin_q[4];
   wire        perr_s   = ~pin_q[5];
   wire        serr_s   = ~pin_q[6];
   wire [31:0] ad_s     = pin_q[38:7];

   function automatic logic [1:0] low_lane(input logic [3:0] be);
      low_lane = be[0] ? 2'd0 : be[1] ? 2'd1 : be[2] ? 2'd2 : be[3] ? 2'd3 : 2'd0;
   endfunction

   function automatic logic [3:0] mem_rd_cmd(input logic [4:0] n, input logic [7:0] cls, input logic basic);
      mem_rd_cmd = (basic || n == 5'd1) ? `PCI_MEM_RD :
                   ({3'b000, n} <= cls) ? `PCI_MEM_RDL : `PCI_MEM_RDM;
   endfunction

   logic [31:0] proxy_command_reg;
   logic [31:0] proxy_address_reg;
   logic [31:0] proxy_data_reg;
   logic [31:0] control_reg;
   logic [3:0]  status_reg;
   logic        proxy_go_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [31:0] hrdata_reg;

   state_type   st_reg;
   logic        job_mem_reg;
   logic        job_write_reg;
   logic [3:0]  job_be_reg;
   logic [3:0]  job_cmd_reg;
   logic [4:0]  job_left_reg;
   logic [31:0] job_addr_reg;
   logic        abort_reg;
   logic        load_next_reg;
   logic [2:0]  ma_cnt_reg;
   logic [7:0]  lat_cnt_reg;
   logic        req_n_reg;
   logic        frame_n_reg;
   logic        frame_oe_reg;
   logic        irdy_n_reg;
   logic        irdy_oe_reg;
   logic [31:0] ad_out_reg;
   logic        ad_oe_reg;
   logic [3:0]  cbe_reg;
   logic        cbe_oe_reg;
   logic        mem_ready_reg;
   logic [31:0] mem_rdata_reg;

   // Zero-wait slave: reads are decoded in the address phase and registered.
   wire        addr_ok = hsel && hready && htrans[1];
   wire [31:0] rd_mux  = (haddr[7:0] == `REG_CMD) ? proxy_command_reg :
                         (haddr[7:0] == `REG_ADR) ? proxy_address_reg :
                         (haddr[7:0] == `REG_DAT) ? proxy_data_reg :
                         (haddr[7:0] == `REG_CTL) ? control_reg :
                         (haddr[7:0] == `REG_STS) ? {28'h000_0000, status_reg} : 32'h0000_0000;
   wire        wr_cmd  = wr_pend_reg && wr_addr_reg == `REG_CMD;
   wire        accept  = wr_cmd && proxy_command_reg[`CMD_READY_BIT];
   wire        idle    = proxy_command_reg[`CMD_READY_BIT];

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_addr_reg <= haddr[7:0];
         end
         if (addr_ok && !hwrite) begin
            hrdata_reg <= rd_mux;
         end
      end
   end

   // Bus phase events, qualified by a detected PCI clock rise except the idle-state take_px and take_mem.
   wire       in_data   = st_reg == ST_DATA && pci_tick;
   wire       phase_ok  = in_data && trdy_s && devsel_s;
   wire       tgt_abort = in_data && stop_s && !devsel_s;
   wire       mst_abort = in_data && !devsel_s && ma_cnt_reg == `MA_TICKS;
   wire [4:0] left_nxt  = job_left_reg - 5'(phase_ok);
   wire       lat_out   = lat_cnt_reg == 8'h00 && !gnt_s;
   wire       end_now   = in_data && frame_n_reg && (phase_ok || stop_s || mst_abort);
   wire       drop_frm  = in_data && !frame_n_reg &&
                          ((phase_ok && (left_nxt == 5'd1 || lat_out)) || stop_s || mst_abort);
   wire       take_px   = st_reg == ST_IDLE && proxy_go_reg;
   wire       take_mem  = st_reg == ST_IDLE && !proxy_go_reg && mem_start;
   wire       turn_tick = st_reg == ST_TURN && pci_tick;
   wire       fin_px    = turn_tick && !job_mem_reg && (abort_reg || job_left_reg == 5'd0);
   wire       bus_busy  = st_reg != ST_IDLE;
   wire [31:0] wsrc     = job_mem_reg ? mem_wdata : proxy_data_reg;

   assign mem_idle = st_reg == ST_IDLE && !proxy_go_reg;

   // Register file; hardware completion wins over software in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         proxy_command_reg <= `CMD_RESET;
         proxy_address_reg <= 32'h0000_0000;
         proxy_data_reg    <= 32'h0000_0000;
         control_reg       <= `CTL_RESET;
         status_reg        <= 4'h0;
         proxy_go_reg      <= 1'b0;
      end else begin
         if (accept) begin
            proxy_command_reg <= hwdata & `CMD_WR_MASK;
            proxy_go_reg      <= 1'b1;
         end else if (take_px) begin
            proxy_go_reg <= 1'b0;
         end
         if (fin_px) begin
            proxy_command_reg[`CMD_READY_BIT] <= 1'b1;
         end
         if (wr_pend_reg && wr_addr_reg == `REG_ADR && idle) begin
            proxy_address_reg <= hwdata;
         end
         // Read word returned to proxy data.
         if (phase_ok && !job_mem_reg && !job_write_reg) begin
            proxy_data_reg <= ad_s;
         end else if (wr_pend_reg && wr_addr_reg == `REG_DAT && idle) begin
            proxy_data_reg <= hwdata;
         end
         if (wr_pend_reg && wr_addr_reg == `REG_CTL) begin
            control_reg <= hwdata;
         end
         status_reg <= ((wr_pend_reg && wr_addr_reg == `REG_STS) ? status_reg & ~hwdata[3:0] : status_reg) |
                       ({3'b000, mst_abort} << `STS_MA_BIT) | ({3'b000, tgt_abort} << `STS_TA_BIT) |
                       ({3'b000, bus_busy && perr_s} << `STS_PERR_BIT) |
                       ({3'b000, bus_busy && serr_s} << `STS_SERR_BIT);
      end
   end

   // Job capture, progress and reissue bookkeeping.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         job_mem_reg   <= 1'b0;
         job_write_reg <= 1'b0;
         job_be_reg    <= 4'h0;
         job_cmd_reg   <= 4'h0;
         job_left_reg  <= 5'd0;
         job_addr_reg  <= 32'h0000_0000;
      end else if (take_px) begin
         job_mem_reg   <= 1'b0;
         job_write_reg <= !proxy_command_reg[`CMD_DIR_BIT];
         job_be_reg    <= proxy_command_reg[`CMD_BE_LSB +: 4];
         job_left_reg  <= 5'd1;
         if (proxy_command_reg[`CMD_TYPE_BIT]) begin
            // Low address bits name lowest byte.
            job_addr_reg <= {proxy_address_reg[31:2], low_lane(proxy_command_reg[`CMD_BE_LSB +: 4])};
            job_cmd_reg  <= proxy_command_reg[`CMD_DIR_BIT] ? `PCI_IO_RD : `PCI_IO_WR;
         end else begin
            job_addr_reg <= proxy_address_reg;
            job_cmd_reg  <= proxy_command_reg[`CMD_DIR_BIT] ? `PCI_CFG_RD : `PCI_CFG_WR;
         end
      end else if (take_mem) begin
         job_mem_reg   <= 1'b1;
         job_write_reg <= mem_write;
         job_be_reg    <= mem_be;
         job_left_reg  <= mem_count;
         job_addr_reg  <= {mem_addr[31:2], 2'b00};
         job_cmd_reg   <= mem_write ? `PCI_MEM_WR :
                          mem_rd_cmd(mem_count, control_reg[`CTL_CLS_LSB +: 8], control_reg[`CTL_BASIC_BIT]);
      end else if (phase_ok || st_reg == ST_FLUSH) begin
         job_left_reg <= job_left_reg - 5'd1;
         job_addr_reg <= job_addr_reg + 32'h0000_0004;
      end
   end

   // Bus sequencer.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= ST_IDLE;
      end else begin
         unique case (st_reg)
            ST_IDLE:  if (take_px || take_mem) st_reg <= ST_REQ;
            ST_REQ:   if (pci_tick && gnt_s) st_reg <= ST_ADDR;
            ST_ADDR:  if (pci_tick) st_reg <= ST_DATA;
            ST_DATA:  if (end_now) st_reg <= ST_TURN;
            ST_TURN: begin
               if (turn_tick) begin
                  if (abort_reg && job_mem_reg && job_left_reg != 5'd0) st_reg <= ST_FLUSH;
                  else if (!abort_reg && job_left_reg != 5'd0) st_reg <= ST_REQ;
                  else st_reg <= ST_IDLE;
               end
            end
            ST_FLUSH: if (job_left_reg == 5'd1) st_reg <= ST_IDLE;
            default:  st_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         abort_reg   <= 1'b0;
         ma_cnt_reg  <= 3'd0;
         lat_cnt_reg <= 8'h00;
      end else begin
         if (st_reg == ST_IDLE) abort_reg <= 1'b0;
         else if (tgt_abort || mst_abort) abort_reg <= 1'b1;
         if (st_reg == ST_ADDR) ma_cnt_reg <= 3'd0;
         else if (in_data && !devsel_s && ma_cnt_reg != `MA_TICKS) ma_cnt_reg <= ma_cnt_reg + 3'd1;
         if (st_reg == ST_REQ) lat_cnt_reg <= control_reg[`CTL_LAT_LSB +: 8];
         else if (in_data && lat_cnt_reg != 8'h00) lat_cnt_reg <= lat_cnt_reg - 8'h01;
      end
   end

   // Pin drivers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_n_reg     <= 1'b1;
         frame_n_reg   <= 1'b1;
         frame_oe_reg  <= 1'b0;
         irdy_n_reg    <= 1'b1;
         irdy_oe_reg   <= 1'b0;
         ad_out_reg    <= 32'h0000_0000;
         ad_oe_reg     <= 1'b0;
         cbe_reg       <= 4'hf;
         cbe_oe_reg    <= 1'b0;
         load_next_reg <= 1'b0;
      end else begin
         load_next_reg <= mem_ready_reg && job_write_reg && st_reg == ST_DATA;
         if (take_px || take_mem || (turn_tick && !abort_reg && job_left_reg != 5'd0)) begin
            req_n_reg <= 1'b0;
         end else if (st_reg == ST_REQ && pci_tick && gnt_s) begin
            req_n_reg    <= 1'b1;
            frame_n_reg  <= 1'b0;
            frame_oe_reg <= 1'b1;
            irdy_oe_reg  <= 1'b1;
            ad_out_reg   <= job_addr_reg;
            ad_oe_reg    <= 1'b1;
            cbe_reg      <= job_cmd_reg;
            cbe_oe_reg   <= 1'b1;
         end else if (st_reg == ST_ADDR && pci_tick) begin
            // Single phase drops frame with irdy.
            irdy_n_reg  <= 1'b0;
            frame_n_reg <= job_left_reg == 5'd1;
            cbe_reg     <= ~job_be_reg;
            ad_oe_reg   <= job_write_reg;
            ad_out_reg  <= wsrc;
         end else if (end_now) begin
            irdy_n_reg <= 1'b1;
            ad_oe_reg  <= 1'b0;
            cbe_oe_reg <= 1'b0;
         end else if (drop_frm) begin
            frame_n_reg <= 1'b1;
         end else if (turn_tick) begin
            frame_oe_reg <= 1'b0;
            irdy_oe_reg  <= 1'b0;
         end
         // Next word is taken a cycle after the ready pulse so the back end can advance.
         if (load_next_reg) begin
            ad_out_reg <= wsrc;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_ready_reg <= 1'b0;
         mem_rdata_reg <= 32'h0000_0000;
      end else begin
         mem_ready_reg <= (phase_ok && job_mem_reg) || st_reg == ST_FLUSH;
         if (phase_ok && job_mem_reg && !job_write_reg) mem_rdata_reg <= ad_s;
      end
   end

   assign mem_ready             = mem_ready_reg;
   assign mem_rdata             = mem_rdata_reg;
   assign bus_request_out_n     = req_n_reg;
   assign frame_out_n           = frame_n_reg;
   assign frame_oe              = frame_oe_reg;
   assign initiator_ready_out_n = irdy_n_reg;
   assign irdy_oe               = irdy_oe_reg;
   assign ad_out                = ad_out_reg;
   assign ad_oe                 = ad_oe_reg;
   assign command_byte_enable_lines = cbe_reg;
   assign cbe_oe                = cbe_oe_reg;

   sequence launch_s;
      accept;
   endsequence
   sequence request_s;
      ##[1:3] !bus_request_out_n;
   endsequence

   req_after_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      launch_s |-> request_s) else $error("bus request did not follow command");
   single_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg == ST_ADDR && pci_tick && job_left_reg == 5'd1) |=> frame_out_n && !initiator_ready_out_n)
      else $error("single phase frame or irdy wrong");
   irdy_stall_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg == ST_DATA && !end_now) |=> !initiator_ready_out_n) else $error("initiator wait state");
   ready_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      fin_px |=> proxy_command_reg[`CMD_READY_BIT]) else $error("ready not set at end");
   ready_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (proxy_go_reg || (bus_busy && !job_mem_reg)) |-> !proxy_command_reg[`CMD_READY_BIT])
      else $error("ready set during transaction");
   mem_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg == ST_ADDR && job_mem_reg) |-> ad_out[1:0] == 2'b00) else $error("memory address low bits");
   be_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg == ST_DATA && job_mem_reg && !job_write_reg) |-> command_byte_enable_lines == ~job_be_reg)
      else $error("read enables changed");
   flush_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg == ST_FLUSH) |=> mem_ready) else $error("abort flush missed ready");
   io_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_reg == ST_ADDR && !job_mem_reg && job_cmd_reg == `PCI_IO_RD) |-> cbe_oe &&
      command_byte_enable_lines == `PCI_IO_RD) else $error("io read code wrong");
endmodule

// ---- pci_master_initiator_map.svh ----
// Register offsets, field positions, reset values and bus codes of the PCI initiator.
`ifndef PCI_MASTER_INITIATOR_MAP_SVH
`define PCI_MASTER_INITIATOR_MAP_SVH

`define REG_CMD        8'h00
`define REG_ADR        8'h04
`define REG_DAT        8'h08
`define REG_CTL        8'h0c
`define REG_STS        8'h10

`define CMD_READY_BIT  31
`define CMD_TYPE_BIT   0
`define CMD_DIR_BIT    4
`define CMD_BE_LSB     8
`define CMD_WR_MASK    32'h0000_0f11
`define CMD_RESET      32'h8000_0000

`define CTL_CLS_LSB    0
`define CTL_LAT_LSB    8
`define CTL_BASIC_BIT  16
`define CTL_RESET      32'h0000_4008

`define STS_MA_BIT     0
`define STS_TA_BIT     1
`define STS_PERR_BIT   2
`define STS_SERR_BIT   3

`define PCI_CFG_RD     4'ha
`define PCI_CFG_WR     4'hb
`define PCI_IO_RD      4'h2
`define PCI_IO_WR      4'h3
`define PCI_MEM_RD     4'h6
`define PCI_MEM_RDL    4'he
`define PCI_MEM_RDM    4'hc
`define PCI_MEM_WR     4'h7

`define MA_TICKS       3'd5
`define PIN_INIT       39'h00_0000_007e

`endif

// ---- pci_master_initiator_tb_top.sv ----
// Self-checking bench for the PCI initiator.
`timescale 1ns/1ps
`include "pci_master_initiator_map.svh"
module pci_master_initiator_tb_top;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_start, mem_write, mem_idle, mem_ready, pci_clk, slow;
   logic bus_grant_in_n, target_ready_in_n, devsel_n, bus_request_out_n, frame_out_n, frame_oe, nodev;
   logic initiator_ready_out_n, irdy_oe, ad_oe, cbe_oe;
   logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, ad_out, ad_t, r, seed, wbase, rcnt, cyc;
   logic [1:0]  htrans;
   logic [4:0]  mem_count;
   logic [3:0]  mem_be, command_byte_enable_lines;
   int          failures, checks_done;
   wire logic        fr = frame_oe ? frame_out_n : 1'b1;
   wire logic        ir = irdy_oe ? initiator_ready_out_n : 1'b1;
   wire logic [31:0] ad_w = ad_oe ? ad_out : ad_t;
   wire logic [3:0]  cbe_w = cbe_oe ? command_byte_enable_lines : 4'hf;
   pci_master_initiator i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_start, .mem_write, .mem_addr, .mem_count, .mem_be,
      .mem_wdata, .mem_idle, .mem_ready, .mem_rdata, .pci_clk_in(pci_clk), .bus_grant_in_n, .target_ready_in_n,
      .devsel_in_n(devsel_n), .stop_in_n(1'b1), .perr_in_n(1'b1), .serr_in_n(1'b1), .ad_in(ad_w),
      .bus_request_out_n, .frame_out_n, .frame_oe, .initiator_ready_out_n, .irdy_oe, .ad_out, .ad_oe,
      .command_byte_enable_lines, .cbe_oe);
   pci_target_model i_tgt (.pci_clk, .slow, .nodev, .req_n(bus_request_out_n), .frame_n(fr), .irdy_n(ir), .ad(ad_w),
      .cbe(cbe_w), .gnt_n(bus_grant_in_n), .trdy_n(target_ready_in_n), .devsel_n, .ad_t);
   initial begin hclk = 0; forever #4 hclk = ~hclk; end
   initial begin pci_clk = 0; #3; forever #62.5 pci_clk = ~pci_clk; end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin failures++; complete_run; end
   end
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk); {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   function automatic logic [1:0] lane(input logic [3:0] be);
      lane = be[0] ? 2'd0 : be[1] ? 2'd1 : be[2] ? 2'd2 : 2'd3;
   endfunction
   task automatic proxy(input logic io, input logic dir, input logic [3:0] ecmd);
      logic [31:0] a, d;
      logic [3:0]  be;
      a = $random(seed); d = $random(seed); be = $random(seed) | 4'h8;
      ahb(1, `REG_DAT, d); ahb(1, `REG_ADR, a); ahb(1, `REG_CMD, {20'h0, be, 3'h0, dir, 3'h0, io});
      ahb(0, `REG_CMD, 0);
      chk(r[31], 0);
      repeat (300) if (!r[31]) ahb(0, `REG_CMD, 0);
      chk(r[31], 1);
      chk(i_tgt.acmd, ecmd);
      chk(i_tgt.acmd_ad & (io ? 32'hffffffff : 32'hfffffffc), {a[31:2], io ? lane(be) : 2'b00});
      chk(i_tgt.dcbe, {~be});
      ahb(0, `REG_DAT, 0);
      chk(r, dir ? 32'h5a5a0000 : d);
      if (!dir) chk(i_tgt.wq[$], d);
      $display("proxy command %h finished", ecmd);
   endtask
   always @(posedge hclk) if (mem_ready === 1'b1) begin
      rcnt <= rcnt + 1;
      mem_wdata <= wbase + rcnt + 1;
      if (!mem_write) chk(mem_rdata, 32'h5a5a0000 ^ rcnt);
   end
   task automatic mem(input logic w, input logic [4:0] n, input logic [3:0] ecmd);
      logic [31:0] a, b;
      logic [3:0]  be;
      a = $random(seed); b = $random(seed); be = $random(seed);
      while (mem_idle !== 1'b1) @(posedge hclk);
      @(posedge hclk); {mem_start, mem_write, mem_addr, mem_count, mem_be} <= {1'b1, w, a, n, be};
      {rcnt, wbase, mem_wdata} <= {32'h0, b, b};
      @(posedge hclk); mem_start <= 0;
      while (rcnt != n) @(posedge hclk);
      chk(i_tgt.acmd, ecmd);
      chk(i_tgt.acmd_ad, {a[31:2], 2'b00});
      for (int i = 0; i < n; i++) if (w && !nodev) chk(i_tgt.wq[i_tgt.wq.size() - n + i], b + i);
      if (!w) chk(i_tgt.dcbe, {~be});
      $display("memory command %h of %0d words finished", ecmd, n);
   endtask
   initial begin
      {seed, hresetn, hsel, htrans, hwrite, haddr, hwdata, slow, nodev, cyc} = {32'h71c299f3, 103'h0};
      {mem_start, mem_write, mem_addr, mem_count, mem_be, mem_wdata, rcnt, wbase} = {2'b0, 32'h0, 5'h1, 100'h0};
      {failures, checks_done} = 0;
      repeat (6) @(posedge hclk); hresetn <= 1;
      repeat (4) @(posedge hclk);
      ahb(0, `REG_CMD, 0); chk(r, 32'h80000000);
      ahb(0, 8'h40, 0); chk(r, 0);
      proxy(0, 1, `PCI_CFG_RD);
      proxy(1, 0, `PCI_IO_WR);
      proxy(1, 1, `PCI_IO_RD);
      slow <= 1; mem(1, 4, `PCI_MEM_WR); mem(1, 1, `PCI_MEM_WR); slow <= 0;
      mem(0, 1, `PCI_MEM_RD); mem(0, 8, `PCI_MEM_RDL); mem(0, 12, `PCI_MEM_RDM);
      ahb(0, `REG_STS, 0); chk(r, 0);
      // An unclaimed burst must master abort and still hand back one ready per word.
      nodev <= 1; mem(1, 3, `PCI_MEM_WR); nodev <= 0;
      ahb(0, `REG_STS, 0); chk(r[`STS_MA_BIT], 1);
      ahb(1, `REG_STS, 32'h0000_000f); ahb(0, `REG_STS, 0); chk(r, 0);
      complete_run;
   end
endmodule

// ---- pci_master_pkg.sv ----
// Types shared by the PCI initiator design.
package pci_master_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_REQ   = 3'b001,
      ST_ADDR  = 3'b010,
      ST_DATA  = 3'b011,
      ST_TURN  = 3'b100,
      ST_FLUSH = 3'b101
   } state_type;
endpackage

// ---- pci_target_model.sv ----
// Behavioural PCI arbiter and target that answers the initiator.
`timescale 1ns/1ps
module pci_target_model (
   input  wire logic        pci_clk,  // Free-running bus clock.
   input  wire logic        slow,     // One wait state per phase after the first.
   input  wire logic        nodev,    // No target claims the cycle.
   input  wire logic        req_n,    // Resolved request.
   input  wire logic        frame_n,  // Resolved frame.
   input  wire logic        irdy_n,   // Resolved initiator ready.
   input  wire logic [31:0] ad,       // Resolved AD.
   input  wire logic [3:0]  cbe,      // Resolved command or enables.
   output logic             gnt_n,    // Grant.
   output logic             trdy_n,   // Target ready.
   output logic             devsel_n, // Device select.
   output logic      [31:0] ad_t      // Target AD drive.
);
   logic        fprev = 1'b1;
   logic        rd = 1'b0;
   logic [3:0]  acmd, dcbe;
   logic [31:0] acmd_ad;
   logic [31:0] k = 32'h0;
   logic [31:0] wq[$];
   initial {gnt_n, trdy_n, devsel_n, ad_t} = {3'h7, 32'h0};
   always @(posedge pci_clk) begin
      fprev <= frame_n;
      if (fprev && !frame_n) begin
         {acmd, acmd_ad, rd, k} <= {cbe, ad, !cbe[0], 32'h0};
      end
      if (!irdy_n && !trdy_n && !devsel_n) begin
         dcbe <= cbe;
         k <= k + 32'h1;
         if (!rd) wq.push_back(ad);
      end
   end
   // Outputs change mid-period so the synchronised samples never race the clock.
   always @(negedge pci_clk) begin
      gnt_n <= req_n;
      devsel_n <= nodev | (frame_n & irdy_n);
      trdy_n <= irdy_n | (slow & ~trdy_n);
      ad_t <= (rd && !irdy_n) ? (32'h5a5a0000 ^ k) : ~ad_t;
   end
endmodule

// ---- pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
module pin_sync #(
   parameter int          W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,   // Sampling clock.
   input  wire logic         rst_n, // Asynchronous reset, active low.
   input  wire logic [W-1:0] d,     // Raw pin levels.
   output logic      [W-1:0] q,     // Filtered levels.
   output logic      [W-1:0] rise   // One-cycle pulse on a filtered rise.
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   wire  [W-1:0] agree = ~(s2_reg ^ s3_reg);
   // A bit only moves once the second and third stages agree.
   wire  [W-1:0] q_next = (s2_reg & agree) | (q & ~agree);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
         q      <= INIT;
         rise   <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q      <= q_next;
         rise   <= q_next & ~q;
      end
   end
endmodule
